// file: hdl/peqc_top.sv
/*
 * Egress control of one switch port: queue index, VID replacement,
 * strict or weighted round robin scheduling and a credit based shaper.
 * Assumes a synchronous register port and a MAC that reports frame end.
 */
// Notes on behaviour
// R01: Queue index bits 1:0 select indexed registers
// R02: Software writes index before indexed access
// R03: Index also reachable as byte at 0x903
// R04: Replace nonzero VID with port default
// R05: Double tagging replaces outer service tag
// R06: Scheduler mode applies with two/four queues
// R07: Code 00: strict priority, queue 3 highest
// R08: Code 10 (reset): weighted round robin
// R09: Software avoids reserved scheduler codes
// R10: Shaper 00 none, 01 credit based
// R11: Seven-bit weight, frames per visit, reset 1
// R12: Weights ignored with a single queue
// R13: Software never programs zero weight
// R14: Suggested weights 8,4,2,1 for four queues
// R15: High water mark bounds credit, reset 0x0534
// R16: Low water mark bounds credit, reset 0x05F2
// R17: Credit increment feeds shaper, reset 0x2000
// R18: Send only with non-negative clamped credit
`timescale 1ns/1ns
module peqc_top #(
    parameter int NQ = 4
) (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    // Register port
    input  wire logic [11:0]           i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [31:0]                o_rdata,
    // Queue state from the buffer manager
    input  wire logic [3:0]            i_q_pending,
    input  wire logic                  i_tx_ready,
    input  wire logic                  i_tx_byte,
    input  wire logic                  i_frame_done,
    input  wire logic                  i_credit_tick,
    // Transmit grant
    output logic                       o_grant,
    output logic [1:0]                 o_grant_queue,
    output logic                       o_sending,
    // Egress header rewrite
    input  wire logic [11:0]           i_port_default_vlan_id,
    input  wire peqc_pkg::peqc_hdr_t   i_hdr,
    output peqc_pkg::peqc_hdr_t        o_hdr
);

    initial begin
        if (NQ != 4) begin
            $error("peqc_top: scheduler is built for four queues");
        end
    end

    localparam int CW = peqc_pkg::CREDIT_W;

    // Register state
    logic [1:0]  qidx_q, qidx_d;
    logic        vid_repl_q, vid_repl_d;
    logic [1:0]  qcount_q, qcount_d;
    logic        dbl_tag_q, dbl_tag_d;
    logic [31:0] rdata_q, rdata_d;

    // Bank write port
    logic                   bank_we;
    peqc_pkg::peqc_field_t  bank_field;
    logic                   bank_upper;
    peqc_pkg::peqc_qcfg_t   cfg [NQ];

    peqc_qcfg_bank #(
        .NQ      (NQ)
    ) u_bank (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_we    (bank_we),
        .i_queue (qidx_q),
        .i_field (bank_field),
        .i_upper (bank_upper),
        .i_wdata (i_wdata[15:0]),
        .o_cfg   (cfg)
    );

    // Register decode
    always_comb begin
        qidx_d     = qidx_q;
        vid_repl_d = vid_repl_q;
        qcount_d   = qcount_q;
        dbl_tag_d  = dbl_tag_q;
        rdata_d    = 32'h0000_0000;
        bank_we    = 1'b0;
        bank_field = peqc_pkg::PEQC_FLD_SCHED_SHAPER;
        bank_upper = 1'b0;
        if (i_wr) begin
            if (i_addr == peqc_pkg::OFS_TXQ_INDEX || i_addr == peqc_pkg::OFS_TXQ_INDEX_BYTE) begin
                qidx_d = i_wdata[peqc_pkg::POS_QIDX +: 2]; // R01 R03
            end else if (i_addr == peqc_pkg::OFS_VID_REPLACE) begin
                vid_repl_d = i_wdata[peqc_pkg::POS_VID_REPL];
            end else if (i_addr == peqc_pkg::OFS_EGRESS_CFG) begin
                qcount_d  = i_wdata[peqc_pkg::POS_QCOUNT +: 2];
                dbl_tag_d = i_wdata[peqc_pkg::POS_DBL_TAG];
            end else if (i_addr == peqc_pkg::OFS_SCHED_SHAPER) begin
                bank_we    = 1'b1; // R01
                bank_field = peqc_pkg::PEQC_FLD_SCHED_SHAPER;
            end else if (i_addr == peqc_pkg::OFS_WRR_WEIGHT) begin
                bank_we    = 1'b1;
                bank_field = peqc_pkg::PEQC_FLD_WEIGHT;
            end else if (i_addr == peqc_pkg::OFS_CBS_HIGH) begin
                bank_we    = 1'b1;
                bank_field = peqc_pkg::PEQC_FLD_HIGH;
            end else if (i_addr == peqc_pkg::OFS_CBS_LOW) begin
                bank_we    = 1'b1;
                bank_field = peqc_pkg::PEQC_FLD_LOW_INCR;
            end else if (i_addr == peqc_pkg::OFS_CBS_INCR) begin
                bank_we    = 1'b1;
                bank_field = peqc_pkg::PEQC_FLD_LOW_INCR;
                bank_upper = 1'b1;
            end
        end
        if (i_rd) begin
            if (i_addr == peqc_pkg::OFS_TXQ_INDEX || i_addr == peqc_pkg::OFS_TXQ_INDEX_BYTE) begin
                rdata_d[peqc_pkg::POS_QIDX +: 2] = qidx_q; // R03
            end else if (i_addr == peqc_pkg::OFS_VID_REPLACE) begin
                rdata_d[peqc_pkg::POS_VID_REPL] = vid_repl_q;
            end else if (i_addr == peqc_pkg::OFS_EGRESS_CFG) begin
                rdata_d[peqc_pkg::POS_QCOUNT +: 2] = qcount_q;
                rdata_d[peqc_pkg::POS_DBL_TAG]     = dbl_tag_q;
            end else if (i_addr == peqc_pkg::OFS_SCHED_SHAPER) begin
                rdata_d[peqc_pkg::POS_SCHED +: 2]  = cfg[qidx_q].sched;
                rdata_d[peqc_pkg::POS_SHAPER +: 2] = cfg[qidx_q].shaper;
            end else if (i_addr == peqc_pkg::OFS_WRR_WEIGHT) begin
                rdata_d[peqc_pkg::POS_WEIGHT +: 7] = cfg[qidx_q].weight;
            end else if (i_addr == peqc_pkg::OFS_CBS_HIGH) begin
                rdata_d[15:0] = cfg[qidx_q].high_mark;
            end else if (i_addr == peqc_pkg::OFS_CBS_LOW) begin
                rdata_d[15:0] = cfg[qidx_q].low_mark;
            end else if (i_addr == peqc_pkg::OFS_CBS_INCR) begin
                rdata_d[15:0] = cfg[qidx_q].incr;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qidx_q     <= peqc_pkg::RST_QIDX;
            vid_repl_q <= peqc_pkg::RST_VID_REPL;
            qcount_q   <= peqc_pkg::RST_QCOUNT;
            dbl_tag_q  <= peqc_pkg::RST_DBL_TAG;
            rdata_q    <= 32'h0000_0000;
        end else begin
            qidx_q     <= qidx_d;
            vid_repl_q <= vid_repl_d;
            qcount_q   <= qcount_d;
            dbl_tag_q  <= dbl_tag_d;
            rdata_q    <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // VID rewrite stage
    peqc_pkg::peqc_hdr_t hdr_q, hdr_d;

    always_comb begin
        hdr_d = i_hdr;
        if (vid_repl_q && i_hdr.valid) begin
            if (dbl_tag_q && i_hdr.has_outer) begin
                if (i_hdr.outer_vid != 12'h000) begin
                    hdr_d.outer_vid = i_port_default_vlan_id; // R05
                end
            end else if (i_hdr.inner_vid != 12'h000) begin
                hdr_d.inner_vid = i_port_default_vlan_id; // R04
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hdr_q <= '0;
        end else begin
            hdr_q <= hdr_d;
        end
    end

    assign o_hdr = hdr_q;

    // Credit based shaper, credit in eighths of a byte
    logic signed [CW-1:0] credit_q [NQ];
    logic signed [CW-1:0] credit_d [NQ];
    logic [1:0]           cur_q, cur_d;
    peqc_pkg::peqc_state_t state_q, state_d;

    always_comb begin
        for (int q = 0; q < NQ; q++) begin
            logic signed [CW-1:0] hi;
            logic signed [CW-1:0] lo;
            logic signed [CW-1:0] nxt;
            hi  = CW'({cfg[q].high_mark, 3'h0}); // R15
            lo  = -CW'({cfg[q].low_mark, 3'h0}); // R16
            nxt = credit_q[q];
            if (cfg[q].shaper != peqc_pkg::PEQC_SHAPE_CBS) begin
                nxt = '0; // R10
            end else if (i_tx_byte && state_q == peqc_pkg::PEQC_ST_SEND && cur_q == 2'(q)) begin
                nxt = credit_q[q] - CW'(1 << peqc_pkg::CREDIT_FRAC); // R18
            end else if (i_credit_tick && i_q_pending[q]) begin
                nxt = credit_q[q] + CW'(cfg[q].incr); // R17
            end
            if (nxt > hi) begin
                nxt = hi; // R18
            end else if (nxt < lo) begin
                nxt = lo;
            end
            credit_d[q] = nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int q = 0; q < NQ; q++) begin
                credit_q[q] <= '0;
            end
        end else begin
            credit_q <= credit_d;
        end
    end

    // Scheduler
    logic [3:0] enabled;
    logic [3:0] elig;
    logic [6:0] wcnt_q, wcnt_d;
    logic       grant_q, grant_d;
    logic [1:0] gq_q;

    always_comb begin
        logic       found;
        logic [1:0] idx;
        logic [6:0] w;
        found   = 1'b0;
        idx     = 2'h0;
        w       = (cfg[cur_q].weight == 7'h00) ? 7'h01 : cfg[cur_q].weight;
        case (qcount_q)
            peqc_pkg::PEQC_QCNT_ONE: enabled = 4'h1;
            peqc_pkg::PEQC_QCNT_TWO: enabled = 4'h3;
            default:                 enabled = 4'hF;
        endcase
        for (int q = 0; q < NQ; q++) begin
            elig[q] = i_q_pending[q] && enabled[q] &&
                      (cfg[q].shaper != peqc_pkg::PEQC_SHAPE_CBS || !credit_q[q][CW-1]); // R18
        end
        state_d = state_q;
        cur_d   = cur_q;
        wcnt_d  = wcnt_q;
        grant_d = 1'b0;
        case (state_q)
            peqc_pkg::PEQC_ST_IDLE: begin
                if (i_tx_ready && elig != 4'h0) begin
                    if (qcount_q == peqc_pkg::PEQC_QCNT_ONE) begin
                        cur_d = 2'h0; // R12 R06
                    end else if (cfg[0].sched == peqc_pkg::PEQC_SCHED_STRICT) begin
                        for (int k = 0; k < NQ; k++) begin
                            if (elig[k]) begin
                                cur_d = 2'(k); // R07
                            end
                        end
                    end else if (elig[cur_q] && wcnt_q < w) begin
                        wcnt_d = wcnt_q + 7'h01; // R08 R11
                    end else begin
                        for (int k = 1; k <= NQ; k++) begin
                            idx = cur_q - 2'(k);
                            if (!found && elig[idx]) begin
                                found = 1'b1;
                                cur_d = idx; // R08
                            end
                        end
                        wcnt_d = 7'h01;
                    end
                    grant_d = 1'b1;
                    state_d = peqc_pkg::PEQC_ST_SEND;
                end
            end
            default: begin
                if (i_frame_done) begin
                    state_d = peqc_pkg::PEQC_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= peqc_pkg::PEQC_ST_IDLE;
            cur_q   <= 2'h0;
            wcnt_q  <= 7'h00;
            grant_q <= 1'b0;
            gq_q    <= 2'h0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            wcnt_q  <= wcnt_d;
            grant_q <= grant_d;
            gq_q    <= cur_d;
        end
    end

    assign o_grant       = grant_q;
    assign o_grant_queue = gq_q;
    assign o_sending     = (state_q == peqc_pkg::PEQC_ST_SEND);

endmodule

// file: shared/peqc_pkg.sv
/*
 * Shared constants and types of the port egress queue control block:
 * register offsets, field positions, reset values, modes and carriers.
 * Assumes one instance per switch port; the port number is decoded upstream.
 */
package peqc_pkg;

    // Register offsets inside the port block (byte granular)
    localparam logic [11:0] OFS_TXQ_INDEX      = 12'h900;
    localparam logic [11:0] OFS_TXQ_INDEX_BYTE = 12'h903;
    localparam logic [11:0] OFS_VID_REPLACE    = 12'h904;
    localparam logic [11:0] OFS_SCHED_SHAPER   = 12'h914;
    localparam logic [11:0] OFS_WRR_WEIGHT     = 12'h915;
    localparam logic [11:0] OFS_CBS_HIGH       = 12'h916;
    localparam logic [11:0] OFS_CBS_LOW        = 12'h918;
    localparam logic [11:0] OFS_CBS_INCR       = 12'h91A;
    localparam logic [11:0] OFS_EGRESS_CFG     = 12'h920;

    // Field positions
    localparam int POS_QIDX       = 0;
    localparam int POS_VID_REPL   = 0;
    localparam int POS_SHAPER     = 4;
    localparam int POS_SCHED      = 6;
    localparam int POS_WEIGHT     = 0;
    localparam int POS_QCOUNT     = 0;
    localparam int POS_DBL_TAG    = 2;

    // Reset values
    localparam logic [1:0]  RST_QIDX      = 2'h0;
    localparam logic        RST_VID_REPL  = 1'b0;
    localparam logic [1:0]  RST_SCHED     = 2'h2;
    localparam logic [1:0]  RST_SHAPER    = 2'h0;
    localparam logic [6:0]  RST_WEIGHT    = 7'h01;
    localparam logic [15:0] RST_CBS_HIGH  = 16'h0534;
    localparam logic [15:0] RST_CBS_LOW   = 16'h05F2;
    localparam logic [15:0] RST_CBS_INCR  = 16'h2000;
    localparam logic [1:0]  RST_QCOUNT    = 2'h2;
    localparam logic        RST_DBL_TAG   = 1'b0;

    // Credit is kept in eighths of a byte
    localparam int          CREDIT_FRAC   = 3;
    localparam int          CREDIT_W      = 21;

    typedef enum logic [1:0] {
        PEQC_SCHED_STRICT = 2'b00,
        PEQC_SCHED_RSV1   = 2'b01,
        PEQC_SCHED_WRR    = 2'b10,
        PEQC_SCHED_RSV3   = 2'b11
    } peqc_sched_t;

    typedef enum logic [1:0] {
        PEQC_SHAPE_NONE = 2'b00,
        PEQC_SHAPE_CBS  = 2'b01,
        PEQC_SHAPE_RSV2 = 2'b10,
        PEQC_SHAPE_RSV3 = 2'b11
    } peqc_shaper_t;

    typedef enum logic [1:0] {
        PEQC_QCNT_ONE  = 2'b00,
        PEQC_QCNT_TWO  = 2'b01,
        PEQC_QCNT_FOUR = 2'b10,
        PEQC_QCNT_RSV  = 2'b11
    } peqc_qcount_t;

    typedef enum logic [1:0] {
        PEQC_FLD_SCHED_SHAPER = 2'b00,
        PEQC_FLD_WEIGHT       = 2'b01,
        PEQC_FLD_HIGH         = 2'b10,
        PEQC_FLD_LOW_INCR     = 2'b11
    } peqc_field_t;

    typedef enum logic [0:0] {
        PEQC_ST_IDLE = 1'b0,
        PEQC_ST_SEND = 1'b1
    } peqc_state_t;

    typedef struct packed {
        logic [1:0]  sched;
        logic [1:0]  shaper;
        logic [6:0]  weight;
        logic [15:0] high_mark;
        logic [15:0] low_mark;
        logic [15:0] incr;
    } peqc_qcfg_t;

    // Egress frame header as seen by the VID rewrite stage
    typedef struct packed {
        logic        valid;
        logic        has_outer;
        logic [11:0] inner_vid;
        logic [11:0] outer_vid;
    } peqc_hdr_t;

endpackage

// file: hdl/peqc_qcfg_bank.sv
/*
 * Per-queue configuration store: one entry per transmit queue, written
 * through a queue number and field selector, all entries visible at once.
 * Assumes the caller presents at most one write per cycle.
 */
`timescale 1ns/1ns
module peqc_qcfg_bank #(
    parameter int NQ = 4
) (
    // Clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    // Write port
    input  wire logic                     i_we,
    input  wire logic [1:0]               i_queue,
    input  wire peqc_pkg::peqc_field_t    i_field,
    input  wire logic                     i_upper,
    input  wire logic [15:0]              i_wdata,
    // Stored settings
    output peqc_pkg::peqc_qcfg_t          o_cfg [NQ]
);

    initial begin
        if (NQ < 1 || NQ > 4) begin
            $error("peqc_qcfg_bank: NQ must be 1 to 4");
        end
    end

    peqc_pkg::peqc_qcfg_t cfg_q [NQ];
    peqc_pkg::peqc_qcfg_t cfg_d [NQ];

    always_comb begin
        for (int q = 0; q < NQ; q++) begin
            cfg_d[q] = cfg_q[q];
            if (i_we && (i_queue == 2'(q))) begin
                case (i_field)
                    peqc_pkg::PEQC_FLD_SCHED_SHAPER: begin
                        cfg_d[q].sched  = i_wdata[peqc_pkg::POS_SCHED +: 2];
                        cfg_d[q].shaper = i_wdata[peqc_pkg::POS_SHAPER +: 2];
                    end
                    peqc_pkg::PEQC_FLD_WEIGHT: begin
                        cfg_d[q].weight = i_wdata[peqc_pkg::POS_WEIGHT +: 7];
                    end
                    peqc_pkg::PEQC_FLD_HIGH: begin
                        cfg_d[q].high_mark = i_wdata;
                    end
                    default: begin
                        if (i_upper) begin
                            cfg_d[q].incr = i_wdata;
                        end else begin
                            cfg_d[q].low_mark = i_wdata;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int q = 0; q < NQ; q++) begin
                cfg_q[q].sched     <= peqc_pkg::RST_SCHED;
                cfg_q[q].shaper    <= peqc_pkg::RST_SHAPER;
                cfg_q[q].weight    <= peqc_pkg::RST_WEIGHT;
                cfg_q[q].high_mark <= peqc_pkg::RST_CBS_HIGH;
                cfg_q[q].low_mark  <= peqc_pkg::RST_CBS_LOW;
                cfg_q[q].incr      <= peqc_pkg::RST_CBS_INCR;
            end
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign o_cfg = cfg_q;

endmodule

// file: test/peqc_top_assertions.sv
/*
 * Checker of the port egress queue control block: register port, grants
 * and header rewrite, seen only through the ports of peqc_top.
 * Assumes one clock and the asynchronous active-low reset of the top.
 */
`timescale 1ns/1ns
module peqc_top_checker #(
    parameter int NQ = 4
) (
    // Clock and reset
    input wire logic                i_mclk,
    input wire logic                i_rst_n,
    // Register port
    input wire logic [11:0]         i_addr,
    input wire logic [31:0]         i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [31:0]         o_rdata,
    // Scheduler
    input wire logic [3:0]          i_q_pending,
    input wire logic                i_tx_ready,
    input wire logic                i_tx_byte,
    input wire logic                i_frame_done,
    input wire logic                i_credit_tick,
    input wire logic                o_grant,
    input wire logic [1:0]          o_grant_queue,
    input wire logic                o_sending,
    // Header rewrite
    input wire logic [11:0]         i_port_default_vlan_id,
    input wire peqc_pkg::peqc_hdr_t i_hdr,
    input wire peqc_pkg::peqc_hdr_t o_hdr
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_idx_write;
        i_wr && (i_addr == peqc_pkg::OFS_TXQ_INDEX || i_addr == peqc_pkg::OFS_TXQ_INDEX_BYTE);
    endsequence
    sequence s_idx_read;
        i_rd && i_addr == peqc_pkg::OFS_TXQ_INDEX;
    endsequence
    sequence s_frame_end;
        o_sending && i_frame_done;
    endsequence

    rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    index_back_a: assert property (s_idx_write ##1 !i_wr ##1 s_idx_read |=>
        o_rdata == {30'h0, $past(i_wdata[1:0], 3)}) else $error("queue index readback wrong");
    weight_width_a: assert property (i_rd && i_addr == peqc_pkg::OFS_WRR_WEIGHT
        |=> o_rdata[31:7] == 25'h0) else $error("weight reserved bits set");
    ctrl_reserved_a: assert property (i_rd && i_addr == peqc_pkg::OFS_SCHED_SHAPER
        |=> o_rdata[31:8] == 24'h0 && o_rdata[3:0] == 4'h0) else $error("control reserved bits set");
    grant_pulse_a: assert property (o_grant |-> o_sending ##1 !o_grant)
        else $error("grant not a single pulse with sending");
    grant_cause_a: assert property (o_grant |-> !$past(o_sending) && $past(i_tx_ready)
        && ($past(i_q_pending) & (4'h1 << o_grant_queue)) != 4'h0) else $error("grant without cause");
    frame_end_a: assert property (s_frame_end |=> !o_sending)
        else $error("sending held after frame end");
    zero_vid_a: assert property (!i_hdr.has_outer && i_hdr.inner_vid == 12'h000
        |=> o_hdr.inner_vid == 12'h000) else $error("zero vid replaced");
    vid_source_a: assert property (1'b1 |=> o_hdr.valid == $past(i_hdr.valid) &&
        (o_hdr.inner_vid == $past(i_hdr.inner_vid) || o_hdr.inner_vid == $past(i_port_default_vlan_id)))
        else $error("inner vid from no source");
    outer_keep_a: assert property (!i_hdr.has_outer |=> o_hdr.outer_vid == $past(i_hdr.outer_vid))
        else $error("outer vid changed without outer tag");
endmodule

bind peqc_top peqc_top_checker #(.NQ(NQ)) i_peqc_top_checker (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_q_pending, .i_tx_ready, .i_tx_byte, .i_frame_done, .i_credit_tick,
    .o_grant, .o_grant_queue, .o_sending, .i_port_default_vlan_id, .i_hdr, .o_hdr);

// file: test/peqc_top_bench.sv
/*
 * Self-checking bench of peqc_top: register tasks, frame grant tasks and
 * header checks, with expectations from the register map and modes.
 * Assumes the WRR visit pointer starts at queue 0 after reset.
 */
`timescale 1ns/1ns
module peqc_top_bench;
    logic                i_mclk, i_rst_n, i_wr, i_rd, i_tx_ready, i_tx_byte, i_frame_done, i_credit_tick;
    logic                o_grant, o_sending;
    logic [1:0]          o_grant_queue;
    logic [3:0]          i_q_pending;
    logic [11:0]         i_addr, i_port_default_vlan_id;
    logic [31:0]         i_wdata, o_rdata;
    peqc_pkg::peqc_hdr_t i_hdr, o_hdr;
    int                  bad_count, check_count, q;

    peqc_top #(.NQ(4)) i_peqc_top (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_q_pending, .i_tx_ready, .i_tx_byte, .i_frame_done, .i_credit_tick, .o_grant,
        .o_grant_queue, .o_sending, .i_port_default_vlan_id, .i_hdr, .o_hdr);

    always #5 i_mclk = ~i_mclk;

    task automatic print_verdict;
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 check($sformatf("rdata %h", a), exp, o_rdata);
    endtask

    // Ready only while a frame is wanted, so no stray grant slips in between
    task automatic frame(input logic [1:0] qx, input int nb);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_tx_ready <= 1'b1;
        while (o_grant !== 1'b1) begin
            @(posedge i_mclk);
            #1 n++;
            if (n > 40) begin
                bad_count++;
                print_verdict();
            end
        end
        check("grant queue", 32'(qx), 32'(o_grant_queue));
        repeat (nb) begin
            @(posedge i_mclk);
            i_tx_byte <= 1'b1;
            @(posedge i_mclk);
            i_tx_byte <= 1'b0;
        end
        @(posedge i_mclk);
        i_frame_done <= 1'b1;
        i_tx_ready <= 1'b0;
        @(posedge i_mclk);
        i_frame_done <= 1'b0;
        #1 check("sending", 32'h0, 32'(o_sending));
    endtask

    task automatic idle_chk(input int n);
        @(posedge i_mclk);
        i_tx_ready <= 1'b1;
        repeat (n) begin
            @(posedge i_mclk);
            #1 check("grant", 32'h0, 32'(o_grant));
        end
        // Drop ready again, else the next frame call misses its grant
        i_tx_ready <= 1'b0;
    endtask

    task automatic hdr(input logic oh, input logic [11:0] iv, ov, ei, eo);
        @(posedge i_mclk);
        i_hdr <= '{1'b1, oh, iv, ov};
        @(posedge i_mclk);
        #1 check("hdr", 32'({1'b1, oh, ei, eo}), 32'(o_hdr));
    endtask

    task automatic tick;
        @(posedge i_mclk);
        i_credit_tick <= 1'b1;
        @(posedge i_mclk);
        i_credit_tick <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        bad_count++;
        print_verdict();
    end

    initial begin
        {i_mclk, i_rst_n, i_wr, i_rd, i_tx_ready, i_tx_byte, i_frame_done, i_credit_tick} = '0;
        {i_addr, i_wdata, i_q_pending, i_hdr, bad_count, check_count} = '0;
        i_port_default_vlan_id = 12'h0AB;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(peqc_pkg::OFS_TXQ_INDEX, 32'h0);
        rd(peqc_pkg::OFS_VID_REPLACE, 32'h0);
        rd(peqc_pkg::OFS_EGRESS_CFG, 32'h2);
        for (q = 0; q < 4; q++) begin
            wr(peqc_pkg::OFS_TXQ_INDEX, 32'(q));
            rd(peqc_pkg::OFS_SCHED_SHAPER, 32'h80);
            rd(peqc_pkg::OFS_WRR_WEIGHT, 32'h01);
            rd(peqc_pkg::OFS_CBS_HIGH, 32'h0534);
            rd(peqc_pkg::OFS_CBS_LOW, 32'h05F2);
            rd(peqc_pkg::OFS_CBS_INCR, 32'h2000);
            wr(peqc_pkg::OFS_WRR_WEIGHT, 32'hFFFFFF80 | (32'h1 << q));
        end
        for (q = 0; q < 4; q++) begin
            wr(peqc_pkg::OFS_TXQ_INDEX_BYTE, 32'(q));
            rd(peqc_pkg::OFS_TXQ_INDEX, 32'(q));
            rd(peqc_pkg::OFS_WRR_WEIGHT, 32'h1 << q);
        end
        wr(12'h908, 32'hFFFFFFFF);
        rd(12'h908, 32'h0);
        wr(peqc_pkg::OFS_TXQ_INDEX, 32'hFFFFFFFF);
        rd(peqc_pkg::OFS_TXQ_INDEX, 32'h3);
        // Pointer starts at queue 0, then a round of 8, 4, 2
        i_q_pending <= 4'hF;
        frame(2'd0, 1);
        for (q = 3; q >= 1; q--)
            repeat (1 << q) frame(2'(q), 1);
        wr(peqc_pkg::OFS_TXQ_INDEX, 32'h0);
        wr(peqc_pkg::OFS_SCHED_SHAPER, 32'h00);
        for (q = 3; q >= 0; q--) begin
            i_q_pending <= 4'((32'h2 << q) - 1);
            repeat (2) frame(2'(q), 1);
        end
        wr(peqc_pkg::OFS_EGRESS_CFG, 32'h0);
        i_q_pending <= 4'hE;
        idle_chk(10);
        i_q_pending <= 4'h1;
        frame(2'd0, 1);
        wr(peqc_pkg::OFS_EGRESS_CFG, 32'h1);
        i_q_pending <= 4'hE;
        frame(2'd1, 1);
        wr(peqc_pkg::OFS_EGRESS_CFG, 32'h2);
        // Credit: 10 bytes cost 80 eighths, each tick returns 40
        wr(peqc_pkg::OFS_TXQ_INDEX, 32'h3);
        wr(peqc_pkg::OFS_SCHED_SHAPER, 32'h90);
        rd(peqc_pkg::OFS_SCHED_SHAPER, 32'h90);
        wr(peqc_pkg::OFS_CBS_INCR, 32'h28);
        i_q_pending <= 4'h8;
        frame(2'd3, 10);
        idle_chk(5);
        tick();
        idle_chk(5);
        tick();
        frame(2'd3, 1);
        hdr(1'b0, 12'h123, 12'h456, 12'h123, 12'h456);
        wr(peqc_pkg::OFS_VID_REPLACE, 32'h1);
        hdr(1'b0, 12'h123, 12'h456, 12'h0AB, 12'h456);
        hdr(1'b0, 12'h000, 12'h456, 12'h000, 12'h456);
        hdr(1'b1, 12'h123, 12'h456, 12'h0AB, 12'h456);
        wr(peqc_pkg::OFS_EGRESS_CFG, 32'h6);
        hdr(1'b1, 12'h123, 12'h456, 12'h123, 12'h0AB);
        print_verdict();
    end
endmodule
